// ### inc/bcc_pkg.sv
// bcc_pkg: constants and carrier types for the buck converter control block.
// assumes a single 100 MHz system clock domain; no interrupts, no buffering.
package bcc_pkg;

   // register indices on the plain register port
   localparam logic [3:0] BCC_ADDR_MODE   = 4'h0;
   localparam logic [3:0] BCC_ADDR_CONFIG = 4'h1;
   localparam logic [3:0] BCC_ADDR_READY  = 4'h2;
   localparam logic [3:0] BCC_ADDR_CTRL   = 4'h3;
   localparam logic [3:0] BCC_ADDR_STATUS = 4'h4;

   // mode register fields
   localparam int BCC_MODE_EN_BIT   = 0;
   localparam int BCC_MODE_ILIM_LSB = 4;
   localparam int BCC_MODE_FBYP_BIT = 1;
   localparam int BCC_MODE_ABYP_BIT = 2;
   localparam int BCC_MODE_SW_BIT   = 3;

   // configuration register fields
   localparam int BCC_CFG_SRC_BIT   = 0;
   localparam int BCC_CFG_INV_BIT   = 1;
   localparam int BCC_CFG_OUTPUT_LEVEL_CODE_LSB  = 3;
   localparam int BCC_CFG_DIV_LSB   = 5;

   // control register fields
   localparam int BCC_CTRL_MIN_PULSE_WIDTH_CODE_LSB = 0;

   // ready register fields
   localparam int BCC_RDY_HIGH_BIT = 7;
   localparam int BCC_RDY_LOW_BIT  = 6;

   // reset values
   localparam logic [2:0] BCC_ILIM_RESET  = 3'h4;   // 500 mA
   localparam logic [3:0] BCC_OUTPUT_LEVEL_CODE_RESET  = 4'h1;   // 1.9 V
   localparam logic [1:0] BCC_MIN_PULSE_WIDTH_CODE_RESET = 2'h1;
   localparam logic [1:0] BCC_DIV_RESET   = 2'h0;

   // peak current codes
   localparam logic [2:0] BCC_ILIM_MIN = 3'h1;
   localparam logic [2:0] BCC_ILIM_MAX = 3'h5;

   // output level range: 1.8 V .. 3.5 V in 0.1 V steps, 18 codes; field holds 16
   localparam logic [3:0] BCC_OUTPUT_LEVEL_CODE_MAX = 4'hF;

   // minimum pulse width codes
   localparam logic [1:0] BCC_MIN_PULSE_WIDTH_CODE_OFF  = 2'h0;
   localparam logic [1:0] BCC_MIN_PULSE_WIDTH_CODE_10NS = 2'h1;
   localparam logic [1:0] BCC_MIN_PULSE_WIDTH_CODE_20NS = 2'h2;

   // timing
   localparam int BCC_CLK_PERIOD_PS = 10000;
   localparam int BCC_MIN_PULSE_WIDTH_CODE_10_PS   = 10000;
   localparam int BCC_MIN_PULSE_WIDTH_CODE_20_PS   = 20000;
   localparam logic [3:0] BCC_MIN_PULSE_WIDTH_CODE_10_CYC = 4'((BCC_MIN_PULSE_WIDTH_CODE_10_PS + BCC_CLK_PERIOD_PS - 1) / BCC_CLK_PERIOD_PS);
   localparam logic [3:0] BCC_MIN_PULSE_WIDTH_CODE_20_CYC = 4'((BCC_MIN_PULSE_WIDTH_CODE_20_PS + BCC_CLK_PERIOD_PS - 1) / BCC_CLK_PERIOD_PS);

   // analog comparator flags from the power stage
   typedef struct packed {
      logic peak_trip;      // peak inductor current above limit
      logic over_target;    // output above programmed target
      logic ready_high;     // output within window, upper comparator
      logic ready_low;      // output within window, lower comparator
      logic margin_low;     // supply exceeds output by under 0.4 V
      logic margin_high;    // supply exceeds output by over 0.5 V
      logic duty_short;     // needed on-time below minimum pulse
   } bcc_comp_s;

   // switch drives to the power stage
   typedef struct packed {
      logic       high_side_switch;
      logic       bypass_switch;
      logic       large_switch;
      logic       osc_run;
      logic [2:0] peak_current_code;
      logic [3:0] output_level_code;
   } bcc_drive_s;

   typedef enum logic [3:0] {
      BCC_OFF    = 4'b0001,
      BCC_CHARGE = 4'b0010,
      BCC_RUN    = 4'b0100,
      BCC_HOLD   = 4'b1000
   } bcc_state_e;

endpackage

// ### src/bcc_conv_clock_divider_code.sv
// bcc_conv_clock_divider_code: converter clock tick generator from the system clock.
// assumes sys_clk at 100 MHz; emits one-cycle ticks, not a derived clock.
`timescale 1ns/1ps
`default_nettype none
module bcc_conv_clock_divider_code
   import bcc_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // control
   input  wire logic [1:0] div_code,
   input  wire logic       invert,
   // tick out
   output logic            tick
);

   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic [2:0] limit;
   logic       tick_ff;
   logic       nxt_tick;

   ////////////////////////////////////////////////////////////////////////////
   // code 10 is printed as divide by two as well; kept that way
   always_comb begin
      case (div_code)
         2'h0:    limit = 3'h0;
         2'h1:    limit = 3'h1;
         2'h2:    limit = 3'h1;
         default: limit = 3'h7;
      endcase
   end

   // inversion moves the tick to count limit >> 1: three cycles later at div 8, a no-op at div 1 and div 2
   always_comb begin
      nxt_cnt  = (cnt_ff >= limit) ? 3'h0 : 3'(cnt_ff + 3'h1);
      nxt_tick = invert ? (cnt_ff == (limit >> 1)) : (cnt_ff == 3'h0);
   end

   // divided count
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_ff  <= 3'h0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule
`default_nettype wire

// ### src/bcc_top.sv
// bcc_top: digital control of the on-chip buck converter.
// assumes comparator inputs are asynchronous; registers via plain strobe port.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bcc_top
   import bcc_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // analog side
   input  wire bcc_comp_s  comp_in,
   input  wire logic       local_osc_tick,
   output bcc_drive_s      drive_out,
   output logic            conv_clock_tick
);

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic       conv_enable_bit_ff;
   logic [2:0] peak_current_code_ff;
   logic       forced_bypass_bit_ff;
   logic       auto_bypass_enable_ff;
   logic       large_switch_ff;
   logic       conv_clock_source_sel_ff;
   logic       conv_clock_invert_ff;
   logic [3:0] output_level_code_ff;
   logic [1:0] conv_clock_divider_code_ff;
   logic [1:0] min_pulse_width_code_ff;
   logic [7:0] reg_rdata_ff;

   // software write: mode register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         conv_enable_bit_ff    <= 1'b0;
         peak_current_code_ff  <= BCC_ILIM_RESET;
         forced_bypass_bit_ff  <= 1'b0;
         auto_bypass_enable_ff <= 1'b0;
         large_switch_ff       <= 1'b0;
      end else if (reg_wr && reg_addr == BCC_ADDR_MODE) begin
         conv_enable_bit_ff    <= reg_wdata[BCC_MODE_EN_BIT];
         peak_current_code_ff  <= reg_wdata[BCC_MODE_ILIM_LSB +: 3];
         forced_bypass_bit_ff  <= reg_wdata[BCC_MODE_FBYP_BIT];
         auto_bypass_enable_ff <= reg_wdata[BCC_MODE_ABYP_BIT];
         large_switch_ff       <= reg_wdata[BCC_MODE_SW_BIT];
      end
   end

   // software write: configuration and control registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         conv_clock_source_sel_ff   <= 1'b0;
         conv_clock_invert_ff       <= 1'b0;
         output_level_code_ff       <= BCC_OUTPUT_LEVEL_CODE_RESET;
         conv_clock_divider_code_ff <= BCC_DIV_RESET;
         min_pulse_width_code_ff    <= BCC_MIN_PULSE_WIDTH_CODE_RESET;
      end else if (reg_wr && reg_addr == BCC_ADDR_CONFIG) begin
         conv_clock_source_sel_ff   <= reg_wdata[BCC_CFG_SRC_BIT];
         conv_clock_invert_ff       <= reg_wdata[BCC_CFG_INV_BIT];
         output_level_code_ff       <= reg_wdata[BCC_CFG_OUTPUT_LEVEL_CODE_LSB +: 4];
         conv_clock_divider_code_ff <= reg_wdata[BCC_CFG_DIV_LSB +: 2];
      end else if (reg_wr && reg_addr == BCC_ADDR_CTRL) begin
         min_pulse_width_code_ff    <= reg_wdata[BCC_CTRL_MIN_PULSE_WIDTH_CODE_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparator synchronisers, two flops per bit

   localparam int COMP_W = $bits(bcc_comp_s);
   logic [COMP_W-1:0] comp_meta_ff;
   logic [COMP_W-1:0] comp_sync_ff;
   logic [1:0]        osc_meta_ff;
   bcc_comp_s         comp;

   genvar gi;
   generate
      for (gi = 0; gi < COMP_W; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               comp_meta_ff[gi] <= 1'b0;
               comp_sync_ff[gi] <= 1'b0;
            end else begin
               comp_meta_ff[gi] <= comp_in[gi];
               comp_sync_ff[gi] <= comp_meta_ff[gi];
            end
         end
      end
   endgenerate

   assign comp = bcc_comp_s'(comp_sync_ff);

   // local oscillator tick: sync then edge detect on the second flop only
   logic osc_prev_ff;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         osc_meta_ff <= 2'h0;
         osc_prev_ff <= 1'b0;
      end else begin
         osc_meta_ff <= {osc_meta_ff[0], local_osc_tick};
         osc_prev_ff <= osc_meta_ff[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // converter clock selection

   logic sys_tick;
   logic conv_tick;

   bcc_conv_clock_divider_code u_div (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .div_code (conv_clock_divider_code_ff),
      .invert   (conv_clock_invert_ff),
      .tick     (sys_tick)
   );

   // divider only matters when the system clock is the source
   assign conv_tick = conv_clock_source_sel_ff ? sys_tick : (osc_meta_ff[1] & ~osc_prev_ff);

   ////////////////////////////////////////////////////////////////////////////
   // minimum pulse width in system cycles

   function automatic logic [3:0] min_pulse_width_code_cycles(input logic [1:0] code);
      case (code)
         BCC_MIN_PULSE_WIDTH_CODE_10NS: min_pulse_width_code_cycles = BCC_MIN_PULSE_WIDTH_CODE_10_CYC;
         BCC_MIN_PULSE_WIDTH_CODE_20NS: min_pulse_width_code_cycles = BCC_MIN_PULSE_WIDTH_CODE_20_CYC;
         default:        min_pulse_width_code_cycles = 4'h0; // 00 and reserved 11: no skipping
      endcase
   endfunction

   logic skip_enable;
   assign skip_enable = (min_pulse_width_code_cycles(min_pulse_width_code_ff) != 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // regulation state machine

   bcc_state_e state_ff;
   bcc_state_e nxt_state;
   logic       hs_ff;
   logic       nxt_hs;
   logic [3:0] on_cnt_ff;
   logic [3:0] nxt_on_cnt;
   logic       limit_hit;

   // in BCC_RUN a tripped comparator always wins over a switching request; the start from BCC_OFF does not check it
   assign limit_hit = comp.peak_trip | comp.over_target;

   always_comb begin
      nxt_state  = state_ff;
      nxt_hs     = hs_ff;
      nxt_on_cnt = on_cnt_ff;
      case (state_ff)
         BCC_OFF: begin
            nxt_hs = 1'b0;
            if (conv_enable_bit_ff) begin
               nxt_state = BCC_CHARGE;
               nxt_hs    = 1'b1;
            end
         end
         BCC_CHARGE: begin
            // on until the output reaches its programmed level, off while the peak comparator trips
            nxt_hs = ~comp.peak_trip;
            if (comp.over_target || comp.ready_low) begin
               nxt_state = BCC_RUN;
               nxt_hs    = 1'b0;
            end
         end
         BCC_RUN: begin
            if (limit_hit) begin
               nxt_hs = 1'b0;
            end else if (conv_tick) begin
               if (skip_enable && comp.duty_short) begin
                  nxt_state = BCC_HOLD;
                  nxt_hs    = 1'b0;
               end else begin
                  nxt_hs     = 1'b1;
                  nxt_on_cnt = min_pulse_width_code_cycles(min_pulse_width_code_ff);
               end
            end else if (on_cnt_ff != 4'h0) begin
               // pulse held for the minimum width unless a tripped comparator cuts it short
               nxt_on_cnt = 4'(on_cnt_ff - 4'h1);
            end else begin
               nxt_hs = 1'b0;
            end
         end
         BCC_HOLD: begin
            // the whole skipped pulse passes with the switch off
            nxt_hs = 1'b0;
            if (conv_tick) begin
               nxt_state = BCC_RUN;
            end
         end
         default: begin
            nxt_state = BCC_OFF;
            nxt_hs    = 1'b0;
         end
      endcase
      if (!conv_enable_bit_ff) begin
         nxt_state  = BCC_OFF;
         nxt_hs     = 1'b0;
         nxt_on_cnt = 4'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff  <= BCC_OFF;
         hs_ff     <= 1'b0;
         on_cnt_ff <= 4'h0;
      end else begin
         state_ff  <= nxt_state;
         hs_ff     <= nxt_hs;
         on_cnt_ff <= nxt_on_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bypass: hysteresis between 0.4 V and 0.5 V margins, independent of enable

   logic auto_hold_ff;
   logic bypass_ff;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         auto_hold_ff <= 1'b0;
      end else if (!auto_bypass_enable_ff) begin
         auto_hold_ff <= 1'b0;
      end else if (comp.margin_low) begin
         auto_hold_ff <= 1'b1;
      end else if (comp.margin_high) begin
         auto_hold_ff <= 1'b0;
      end
   end

   // registered so the switch never glitches on comparator chatter; works with regulator off
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bypass_ff <= 1'b0;
      end else begin
         bypass_ff <= forced_bypass_bit_ff | auto_hold_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   bcc_drive_s drive_ff;
   logic       tick_out_ff;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         drive_ff    <= '0;
         tick_out_ff <= 1'b0;
      end else begin
         drive_ff.high_side_switch  <= hs_ff;
         drive_ff.bypass_switch     <= bypass_ff;
         drive_ff.large_switch      <= large_switch_ff;
         drive_ff.osc_run           <= conv_enable_bit_ff;
         drive_ff.peak_current_code <= peak_current_code_ff;
         drive_ff.output_level_code <= output_level_code_ff;
         tick_out_ff                <= conv_tick;
      end
   end

   assign drive_out       = drive_ff;
   assign conv_clock_tick = tick_out_ff;

   ////////////////////////////////////////////////////////////////////////////
   // register read, data one cycle after the strobe

   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         BCC_ADDR_MODE: begin
            rd_mux[BCC_MODE_EN_BIT]        = conv_enable_bit_ff;
            rd_mux[BCC_MODE_FBYP_BIT]      = forced_bypass_bit_ff;
            rd_mux[BCC_MODE_ABYP_BIT]      = auto_bypass_enable_ff;
            rd_mux[BCC_MODE_SW_BIT]        = large_switch_ff;
            rd_mux[BCC_MODE_ILIM_LSB +: 3] = peak_current_code_ff;
         end
         BCC_ADDR_CONFIG: begin
            rd_mux[BCC_CFG_SRC_BIT]        = conv_clock_source_sel_ff;
            rd_mux[BCC_CFG_INV_BIT]        = conv_clock_invert_ff;
            rd_mux[BCC_CFG_OUTPUT_LEVEL_CODE_LSB +: 4]  = output_level_code_ff;
            rd_mux[BCC_CFG_DIV_LSB +: 2]   = conv_clock_divider_code_ff;
         end
         BCC_ADDR_READY: begin
            rd_mux[BCC_RDY_HIGH_BIT]       = comp.ready_high;
            rd_mux[BCC_RDY_LOW_BIT]        = comp.ready_low;
         end
         BCC_ADDR_CTRL: begin
            rd_mux[BCC_CTRL_MIN_PULSE_WIDTH_CODE_LSB +: 2] = min_pulse_width_code_ff;
         end
         BCC_ADDR_STATUS: begin
            rd_mux[3:0] = state_ff;
            rd_mux[4]   = hs_ff;
            rd_mux[5]   = bypass_ff;
            rd_mux[6]   = auto_hold_ff;
         end
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
      end else begin
         reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata = reg_rdata_ff;

endmodule
`default_nettype wire

// ### sim/bcc_stage_model.sv
// bcc_stage_model: behavioural power stage facing the control block.
// assumes the bench sets every comparator flag except the ready pair.
`timescale 1ns/1ps
`default_nettype none
module bcc_stage_model
   import bcc_pkg::*;
(
   // clock and bench control
   input  wire logic       sys_clk,
   input  wire logic       drain,
   input  wire bcc_comp_s  cmd,
   // control block side
   input  wire bcc_drive_s drive,
   output bcc_comp_s       comp,
   output logic            osc
);
   logic [3:0] chg_ff;
   ////////////////////////////////////////////////////////////////////////////
   // output charges only while the high-side switch conducts
   always_ff @(posedge sys_clk) begin
      if (drain) begin
         chg_ff <= 4'h0;
      end else if (drive.high_side_switch && chg_ff != 4'hF) begin
         chg_ff <= chg_ff + 4'h1;
      end
   end
   // ready window opens after a few cycles of charge
   always_comb begin
      comp = cmd;
      comp.ready_high = chg_ff > 4'h5;
      comp.ready_low = chg_ff > 4'h5;
   end
   // local oscillator runs free at a fixed rate, never trimmed faster; its phase drifts against sys_clk
   initial begin
      osc = 1'b0;
      forever #21 osc = ~osc;
   end
endmodule
`default_nettype wire

// ### sim/bcc_checker_assertions.sv
// bcc_checker: port-level properties of the buck converter control block.
// assumes one sys_clk domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bcc_checker
   import bcc_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_rdata,
   // analog side
   input  wire bcc_comp_s  comp_in,
   input  wire logic       local_osc_tick,
   input  wire bcc_drive_s drive_out,
   input  wire logic       conv_clock_tick
);
   logic [2:0] up_ff;
   logic [7:0] mode_ff;
   logic       mode_wr;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   assign mode_wr = reg_wr && reg_addr == BCC_ADDR_MODE;
   // shadow of the mode register; up_ff masks the registered outputs' settling
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         up_ff <= 3'h0;
         mode_ff <= 8'h40;
      end else begin
         if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
         if (mode_wr) mode_ff <= reg_wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_read_idle: assert property (up_ff == 3'h7 && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_unmapped_read: assert property (reg_rd && reg_addr > BCC_ADDR_STATUS |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_mode_readback: assert property (reg_rd && reg_addr == BCC_ADDR_MODE |=> reg_rdata[6:0] == mode_ff[6:0])
      else $error("mode readback wrong");
   a_drive_codes: assert property ((up_ff == 3'h7 && $stable(mode_ff))[*3]
      |-> {drive_out.large_switch, drive_out.peak_current_code} == {mode_ff[3], mode_ff[6:4]})
      else $error("switch size or peak code not driven");
   a_enable_start: assert property (mode_wr && reg_wdata[0] && !mode_ff[0] && comp_in == '0
      |-> ##[1:3] drive_out.high_side_switch) else $error("enable did not start charging");
   a_off_quiet: assert property ((up_ff == 3'h7 && !mode_ff[0])[*4] |-> !drive_out.high_side_switch)
      else $error("switching while disabled");
   a_peak_stop: assert property (comp_in.peak_trip[*5] |-> !drive_out.high_side_switch)
      else $error("switching through peak trip");
   a_over_stop: assert property (comp_in.over_target[*5] |-> !drive_out.high_side_switch)
      else $error("switching above target");
   a_forced_bypass: assert property (mode_wr && reg_wdata[1] |-> ##[2:4] drive_out.bypass_switch)
      else $error("forced bypass not closed");
   a_auto_close: assert property ((mode_ff[2] && comp_in.margin_low)[*6] |-> drive_out.bypass_switch)
      else $error("auto bypass not closed");
   a_auto_open: assert property ((!mode_ff[1] && comp_in.margin_high && !comp_in.margin_low)[*6]
      |-> !drive_out.bypass_switch) else $error("bypass not reopened");
   c_start: cover property (mode_wr && reg_wdata[0] ##[1:3] drive_out.high_side_switch);
   c_auto: cover property (mode_ff[2] && comp_in.margin_low ##4 drive_out.bypass_switch);
   c_trip: cover property (comp_in.peak_trip[*5]);
endmodule
bind bcc_top bcc_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_in(comp_in),
   .local_osc_tick(local_osc_tick), .drive_out(drive_out), .conv_clock_tick(conv_clock_tick));
`default_nettype wire

// ### sim/tb.sv
// tb: self-checking bench for bcc_top beside the power stage model.
// assumes 100 MHz sys_clk and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tb
   import bcc_pkg::*;
;
   logic       sys_clk, rst_n, reg_wr, reg_rd, drain, local_osc_tick, conv_clock_tick;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_val, tk, hc, h1;
   bcc_comp_s  cmd, comp_in;
   bcc_drive_s drive_out;
   int         err_count, compares;
   logic [7:0] exp_tk [4] = '{8'h40, 8'h20, 8'h20, 8'h08};
   ////////////////////////////////////////////////////////////////////////////
   bcc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_in(comp_in),
      .local_osc_tick(local_osc_tick), .drive_out(drive_out), .conv_clock_tick(conv_clock_tick));
   bcc_stage_model u_stage (.sys_clk(sys_clk), .drain(drain), .cmd(cmd), .drive(drive_out),
      .comp(comp_in), .osc(local_osc_tick));
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // every bus task starts and ends on a rising edge; a spare cycle keeps strobes apart
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      cyc(1);
   endtask
   // count converter ticks and high-side cycles over 64 system cycles
   task automatic count64();
      tk = 8'h00;
      hc = 8'h00;
      repeat (64) begin
         @(posedge sys_clk);
         #1 tk = tk + {7'h00, conv_clock_tick};
         hc = hc + {7'h00, drive_out.high_side_switch};
      end
      cyc(1);
   endtask
   task automatic wait_hs(input logic lvl);
      int n;
      n = 0;
      // look a moment after the edge so the registered output has settled
      #1;
      while (drive_out.high_side_switch !== lvl && n < 50) begin
         cyc(1);
         #1 n++;
      end
      cyc(1);
      if (n == 50) begin
         err_count++;
         complete_run();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(BCC_ADDR_MODE);   check(rd_val, 8'h40);
      rd(BCC_ADDR_CONFIG); check(rd_val, 8'h08);
      rd(BCC_ADDR_CTRL);   check(rd_val, 8'h01);
      check({4'h0, drive_out.output_level_code}, {4'h0, BCC_OUTPUT_LEVEL_CODE_RESET});
      wr(4'hA, 8'hFF);
      rd(4'hA);            check(rd_val, 8'h00);
      wr(BCC_ADDR_READY, 8'hFF);
      rd(BCC_ADDR_READY);  check(rd_val, 8'h00);
   endtask
   task automatic t_codes();
      for (int c = 1; c <= 5; c++) begin
         wr(BCC_ADDR_MODE, {1'b0, c[2:0], 4'h8});
         cyc(3);
         check({4'h0, drive_out.large_switch, drive_out.peak_current_code}, {5'h01, c[2:0]});
      end
      wr(BCC_ADDR_MODE, 8'h40);
      cyc(3);
      check({7'h0, drive_out.large_switch}, 8'h00);
      wr(BCC_ADDR_CONFIG, 8'h60);
      cyc(3);
      check({4'h0, drive_out.output_level_code}, 8'h0C);
   endtask
   task automatic t_start();
      drain <= 1'b0;
      wr(BCC_ADDR_MODE, 8'h41);
      wait_hs(1'b1);
      check({7'h0, drive_out.osc_run}, 8'h01);
      cyc(20);
      rd(BCC_ADDR_STATUS); check(rd_val & 8'h0F, 8'h04);
      rd(BCC_ADDR_READY);  check(rd_val & 8'hC0, 8'hC0);
      cmd.peak_trip <= 1'b1;
      cyc(4);
      count64();           check(hc, 8'h00);
      cmd.peak_trip <= 1'b0;
      cmd.over_target <= 1'b1;
      cyc(4);
      count64();           check(hc, 8'h00);
      cmd.over_target <= 1'b0;
   endtask
   task automatic t_clock();
      for (int c = 0; c < 4; c++) begin
         wr(BCC_ADDR_CONFIG, {1'b0, c[1:0], 5'h01});
         cyc(4);
         count64();        check(tk, exp_tk[c]);
      end
      wr(BCC_ADDR_CONFIG, 8'h63);
      cyc(4);
      count64();           check(tk, 8'd8);
      wr(BCC_ADDR_CONFIG, 8'h60);
      cyc(4);
      count64();           check({7'h0, tk > 8'd12 && tk < 8'd18}, 8'h01);
      wr(BCC_ADDR_CONFIG, 8'h08);
   endtask
   task automatic t_skip();
      cmd.duty_short <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(BCC_ADDR_CTRL, {6'h00, c[1:0]});
         cyc(4);
         count64();        check({7'h0, hc == 8'h00}, {7'h0, c == 1 || c == 2});
      end
      cmd.duty_short <= 1'b0;
      wr(BCC_ADDR_CTRL, 8'h01);
      count64();
      h1 = hc;
      wr(BCC_ADDR_CTRL, 8'h02);
      count64();           check({7'h0, hc > h1 && h1 > 8'h00}, 8'h01);
   endtask
   task automatic t_bypass();
      wr(BCC_ADDR_MODE, 8'h43);
      wr(BCC_ADDR_MODE, 8'h02);
      wait_hs(1'b0);
      cyc(4);
      check({7'h0, drive_out.bypass_switch}, 8'h01);
      rd(BCC_ADDR_STATUS); check(rd_val & 8'h0F, 8'h01);
      check({7'h0, drive_out.osc_run}, 8'h00);
      wr(BCC_ADDR_MODE, 8'h00);
      cyc(6);              check({7'h0, drive_out.bypass_switch}, 8'h00);
      wr(BCC_ADDR_MODE, 8'h04);
      cmd.margin_low <= 1'b1;
      cyc(6);              check({7'h0, drive_out.bypass_switch}, 8'h01);
      cmd.margin_low <= 1'b0;
      cyc(6);              check({7'h0, drive_out.bypass_switch}, 8'h01);
      cmd.margin_high <= 1'b1;
      cyc(6);              check({7'h0, drive_out.bypass_switch}, 8'h00);
      wr(BCC_ADDR_MODE, 8'h06);
      cyc(6);              check({7'h0, drive_out.bypass_switch}, 8'h01);
      wr(BCC_ADDR_MODE, 8'h04);
      cyc(6);              check({7'h0, drive_out.bypass_switch}, 8'h00);
      cmd.margin_high <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // main sequence: reset, then each scenario in turn
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      cmd = '0;
      drain = 1'b1;
      err_count = 0;
      compares = 0;
      cyc(10);
      rst_n <= 1'b1;
      cyc(1);
      t_regs();
      t_codes();
      t_start();
      t_clock();
      t_skip();
      t_bypass();
      complete_run();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
